/* shared/seek_params.svh */
`ifndef SEEK_PARAMS_SVH
`define SEEK_PARAMS_SVH
`define CLK_MHZ 100
`define SRT_UNIT_US 500
`define SRT_UNIT_CYC (`SRT_UNIT_US * `CLK_MHZ)
`define STEP_PULSE_CYC 8
`define RECAL_MAX_STEPS 8'h4F
`define FIRST_GAP_DIV 2
`define IC_NORMAL 2'h0
`define IC_ABNORMAL 2'h1
`define GAP4A_LEN 8'h50
`define SYNC_LEN 8'h0C
`define GAP1_LEN 8'h32
`define GAP2_LEN 8'h16
`define GAP_FILL 8'h4E
`define SYNC_FILL 8'h00
`define GPL_RW_512_MFM 8'h2A
`define GPL_FMT_512_MFM 8'h50
`define INDEX_LIMIT 2'h2
`endif

/* shared/seek_pkg.sv */
package seek_pkg;
    typedef enum logic [1:0] {CMD_NONE, CMD_SEEK, CMD_RECAL, CMD_READ_ID} cmd_op_t;
    typedef struct packed {
        cmd_op_t op;
        logic [1:0] drive;
        logic [7:0] target_cylinder;
    } cmd_t;
    typedef struct packed {
        logic [7:0] cyl;
        logic [7:0] head;
        logic [7:0] sector;
        logic [7:0] size;
    } id_field_t;
    typedef struct packed {
        logic [1:0] interrupt_code_field;
        logic seek_end_flag;
        logic equipment_check_flag;
        logic head_bit;
        logic [1:0] drive;
    } status_zero_t;
    typedef struct packed {
        logic [7:0] gap4a_len;
        logic [7:0] sync_len;
        logic [7:0] gap1_len;
        logic [7:0] gap2_len;
        logic [7:0] gap_fill;
    } fmt_layout_t;
endpackage

/* src/seek_recal_ctrl.sv */
`timescale 1ns/100ps
`include "seek_params.svh"
// Rules of the document for this block and its host
// RULE_01 - Double-density format gaps: 80, 12, 50, 22.
// RULE_02 - Host picks read/write gap 0x2A.
// RULE_03 - Host picks format gap 0x50.
// RULE_04 - Only Read ID, Recalibrate, Seek interrupt.
// RULE_05 - Read ID captures first good ID field.
// RULE_06 - No mark by second index: abnormal, missing-mark.
// RULE_07 - Seek and Recalibrate return no result bytes.
// RULE_08 - Host follows with Sense Interrupt Status.
// RULE_09 - Recalibrate clears cylinder, samples track zero.
// RULE_10 - Track zero low: direction out, keep stepping.
// RULE_11 - Track zero high: seek end, terminate.
// RULE_12 - After 79 steps: seek end plus equipment check.
// RULE_13 - Host senses status after each Recalibrate.
// RULE_14 - Busy only during command phase.
// RULE_15 - Host recalibrates after power-up.
// RULE_16 - Seek direction from cylinder comparison.
// RULE_17 - Steps spaced by programmed step rate.
// RULE_18 - Recompare after each step; equal ends seek.
// RULE_19 - Host seeks, senses, reads ID without implied seek.
// RULE_20 - Seek reports head bit zero.
// RULE_21 - Leaving low power clears cylinders and status.
// RULE_22 - Host services interrupts before low power.
// RULE_23 - Sense status clears interrupt, reports cause.
// RULE_24 - First step interval may be shorter.
// RULE_25 - Per-drive cylinder counter, one per step.
module seek_recal_ctrl
(
    // Clock and reset.
    input wire logic clock_i,
    input wire logic reset_i,
    // Command port.
    input wire logic cmd_valid_i,
    input wire seek_pkg::cmd_t cmd_i,
    input wire logic sense_i,
    input wire logic [3:0] step_rate_time_i,
    input wire logic low_power_cmd_i,
    // Read channel.
    input wire logic id_valid_i,
    input wire seek_pkg::id_field_t id_i,
    // Drive lines.
    input wire logic track_zero_in_i,
    input wire logic index_i,
    output logic step_o,
    output logic dir_o,
    output logic [1:0] drive_sel_o,
    // Status.
    output logic busy_o,
    output logic irq_o,
    output seek_pkg::status_zero_t status_reg_zero_o,
    output logic missing_address_mark_flag_o,
    output seek_pkg::id_field_t id_o,
    output logic [7:0] present_cylinder_o,
    output seek_pkg::fmt_layout_t fmt_layout_o
);
    import seek_pkg::*;
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_CMD = 5'h02,
        S_WAIT = 5'h04,
        S_STEP = 5'h08,
        S_RDID = 5'h10
    } state_t;
    state_t state_r, state_nxt;
    cmd_t cmd_r, cmd_nxt;
    logic [7:0] pcn_r [4];
    logic [7:0] pcn_nxt [4];
    logic [23:0] timer_r, timer_nxt;
    logic [7:0] steps_r, steps_nxt;
    logic [1:0] idx_r, idx_nxt;
    logic idx_d_r, first_r, first_nxt;
    logic step_r, step_nxt, dir_r, dir_nxt, busy_r, busy_nxt, irq_r, irq_nxt, ma_r, ma_nxt;
    status_zero_t st_r, st_nxt;
    id_field_t id_r, id_nxt;
    logic [23:0] interval;
    logic [7:0] pc;
    // Interval is (16 - value) units; first interval is halved.
    always_comb
    begin
        interval = 24'(({1'b0, 4'hF - step_rate_time_i} + 5'h01) * `SRT_UNIT_CYC); // [RULE_17]
        if (first_r)
            interval = 24'(interval / `FIRST_GAP_DIV); // [RULE_24]
    end
    assign pc = pcn_r[cmd_r.drive];
    always_comb
    begin
        state_nxt = state_r;
        cmd_nxt = cmd_r;
        pcn_nxt = pcn_r;
        timer_nxt = timer_r;
        steps_nxt = steps_r;
        idx_nxt = idx_r;
        first_nxt = first_r;
        step_nxt = 1'b0;
        dir_nxt = dir_r;
        busy_nxt = 1'b0;
        irq_nxt = irq_r;
        ma_nxt = ma_r;
        st_nxt = st_r;
        id_nxt = id_r;
        if (sense_i)
            irq_nxt = 1'b0; // [RULE_23]
        unique case (state_r)
            S_IDLE:
            begin
                if (cmd_valid_i && cmd_i.op != CMD_NONE)
                begin
                    cmd_nxt = cmd_i;
                    steps_nxt = 8'h00;
                    busy_nxt = 1'b1; // [RULE_14]
                    state_nxt = S_CMD;
                end
            end
            S_CMD:
            begin
                steps_nxt = 8'h00;
                idx_nxt = 2'h0;
                first_nxt = 1'b1;
                timer_nxt = 24'h0;
                if (cmd_r.op == CMD_RECAL)
                    pcn_nxt[cmd_r.drive] = 8'h00; // [RULE_09]
                state_nxt = (cmd_r.op == CMD_READ_ID) ? S_RDID : S_WAIT;
            end
            S_WAIT:
            begin
                if (timer_r != 24'h0)
                    timer_nxt = timer_r - 24'h1;
                else if (cmd_r.op == CMD_RECAL)
                begin
                    if (track_zero_in_i || steps_r == `RECAL_MAX_STEPS) // [RULE_11] [RULE_12]
                    begin
                        st_nxt = '{`IC_NORMAL, 1'b1, ~track_zero_in_i, 1'b0, cmd_r.drive};
                        irq_nxt = 1'b1; // [RULE_04] [RULE_07]
                        state_nxt = S_IDLE;
                    end
                    else
                    begin
                        dir_nxt = 1'b0; // [RULE_10]
                        step_nxt = 1'b1;
                        state_nxt = S_STEP;
                    end
                end
                else if (pc == cmd_r.target_cylinder)
                begin
                    st_nxt = '{`IC_NORMAL, 1'b1, 1'b0, 1'b0, cmd_r.drive}; // [RULE_18] [RULE_20]
                    irq_nxt = 1'b1; // [RULE_04] [RULE_07]
                    state_nxt = S_IDLE;
                end
                else
                begin
                    dir_nxt = pc < cmd_r.target_cylinder; // [RULE_16]
                    step_nxt = 1'b1;
                    state_nxt = S_STEP;
                end
            end
            S_STEP:
            begin
                if (cmd_r.op == CMD_SEEK)
                    pcn_nxt[cmd_r.drive] = dir_r ? pc + 8'h01 : pc - 8'h01; // [RULE_25]
                steps_nxt = steps_r + 8'h01;
                timer_nxt = interval; // [RULE_17]
                first_nxt = 1'b0;
                state_nxt = S_WAIT;
            end
            S_RDID:
            begin
                if (id_valid_i)
                begin
                    id_nxt = id_i; // [RULE_05]
                    st_nxt = '{`IC_NORMAL, 1'b0, 1'b0, id_i.head[0], cmd_r.drive};
                    irq_nxt = 1'b1; // [RULE_04]
                    state_nxt = S_IDLE;
                end
                else if (index_i && !idx_d_r)
                begin
                    idx_nxt = idx_r + 2'h1;
                    if (idx_r + 2'h1 == `INDEX_LIMIT)
                    begin
                        st_nxt = '{`IC_ABNORMAL, 1'b0, 1'b0, 1'b0, cmd_r.drive}; // [RULE_06]
                        ma_nxt = 1'b1; // [RULE_06]
                        irq_nxt = 1'b1;
                        state_nxt = S_IDLE;
                    end
                end
            end
        endcase
        if (state_r == S_IDLE && cmd_valid_i && cmd_i.op == CMD_READ_ID)
            ma_nxt = 1'b0;
        if (low_power_cmd_i)
        begin
            for (int i = 0; i < 4; i++)
                pcn_nxt[i] = 8'h00; // [RULE_21]
            st_nxt = '0; // [RULE_21]
            ma_nxt = 1'b0;
            irq_nxt = 1'b0;
            state_nxt = S_IDLE;
        end
    end
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            state_r <= S_IDLE;
            cmd_r <= '0;
            pcn_r <= '{default: 8'h00};
            timer_r <= 24'h0;
            steps_r <= 8'h00;
            idx_r <= 2'h0;
            idx_d_r <= 1'b0;
            first_r <= 1'b1;
            step_r <= 1'b0;
            dir_r <= 1'b0;
            busy_r <= 1'b0;
            irq_r <= 1'b0;
            ma_r <= 1'b0;
            st_r <= '0;
            id_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            cmd_r <= cmd_nxt;
            pcn_r <= pcn_nxt;
            timer_r <= timer_nxt;
            steps_r <= steps_nxt;
            idx_r <= idx_nxt;
            idx_d_r <= index_i;
            first_r <= first_nxt;
            step_r <= step_nxt;
            dir_r <= dir_nxt;
            busy_r <= busy_nxt;
            irq_r <= irq_nxt;
            ma_r <= ma_nxt;
            st_r <= st_nxt;
            id_r <= id_nxt;
        end
    end
    logic [7:0] pco_r;
    fmt_layout_t fmt_r;
    always_ff @(posedge clock_i)
    begin
        pco_r <= reset_i ? 8'h00 : pc;
        fmt_r <= '{`GAP4A_LEN, `SYNC_LEN, `GAP1_LEN, `GAP2_LEN, `GAP_FILL}; // [RULE_01]
    end
    assign step_o = step_r;
    assign dir_o = dir_r;
    assign drive_sel_o = cmd_r.drive;
    assign busy_o = busy_r;
    assign irq_o = irq_r;
    assign status_reg_zero_o = st_r;
    assign missing_address_mark_flag_o = ma_r;
    assign id_o = id_r;
    assign present_cylinder_o = pco_r;
    assign fmt_layout_o = fmt_r;
    property p_busy_short;
        @(posedge clock_i) disable iff (reset_i) busy_o |=> !busy_o;
    endproperty
    a_busy_short: assert property (p_busy_short) else $error("busy too long"); // [RULE_14]
    property p_recal_dir;
        @(posedge clock_i) disable iff (reset_i) step_o && cmd_r.op == CMD_RECAL |-> !dir_o;
    endproperty
    a_recal_dir: assert property (p_recal_dir) else $error("recal dir"); // [RULE_10]
    property p_seek_head;
        @(posedge clock_i) disable iff (reset_i) $rose(irq_o) && cmd_r.op == CMD_SEEK
            |-> status_reg_zero_o.seek_end_flag && !status_reg_zero_o.head_bit;
    endproperty
    a_seek_head: assert property (p_seek_head) else $error("seek status"); // [RULE_20]
    property p_recal_clear;
        @(posedge clock_i) disable iff (reset_i) state_r == S_CMD && cmd_r.op == CMD_RECAL
            && !low_power_cmd_i |=> pcn_r[cmd_r.drive] == 8'h00;
    endproperty
    a_recal_clear: assert property (p_recal_clear) else $error("pcn not cleared"); // [RULE_09]
    property p_max_steps;
        @(posedge clock_i) disable iff (reset_i)
            steps_r <= `RECAL_MAX_STEPS || cmd_r.op != CMD_RECAL;
    endproperty
    a_max_steps: assert property (p_max_steps) else $error("too many steps"); // [RULE_12]
    property p_sense;
        @(posedge clock_i) disable iff (reset_i) sense_i && state_r == S_IDLE |=> !irq_o;
    endproperty
    a_sense: assert property (p_sense) else $error("irq not cleared"); // [RULE_23]
    property p_ma;
        @(posedge clock_i) disable iff (reset_i) $rose(missing_address_mark_flag_o)
            |-> status_reg_zero_o.interrupt_code_field == `IC_ABNORMAL;
    endproperty
    a_ma: assert property (p_ma) else $error("ma code"); // [RULE_06]
    property p_lowpow;
        @(posedge clock_i) disable iff (reset_i)
            low_power_cmd_i |=> status_reg_zero_o == '0 ##1 present_cylinder_o == 8'h00;
    endproperty
    a_lowpow: assert property (p_lowpow) else $error("low power clear"); // [RULE_21]

    c_seek: cover property (@(posedge clock_i) $rose(irq_o) && cmd_r.op == CMD_SEEK);
    c_recal_ec: cover property (@(posedge clock_i) $rose(status_reg_zero_o.equipment_check_flag));
    c_rdid_ma: cover property (@(posedge clock_i) $rose(missing_address_mark_flag_o));
endmodule // seek_recal_ctrl

/* sim/drive_model.sv */
`timescale 1ns/100ps
module drive_model
#(
    parameter int INDEX_PERIOD = 3000
)
(
    // Clock and reset.
    input wire logic clock_i,
    input wire logic reset_i,
    // Head control.
    input wire logic step_i,
    input wire logic dir_i,
    input wire logic [1:0] drive_sel_i,
    // Drive status lines.
    output logic track_zero_o,
    output logic index_o
);
    logic [7:0] pos_r [4];
    int index_cnt_r;
    // Each drive moves its own head one track per step pulse, except outward at track zero, where it holds.
    always @(posedge clock_i)
    begin
        if (reset_i)
        begin
            pos_r <= '{default: 8'h00};
            index_cnt_r <= 0;
        end
        else
        begin
            index_cnt_r <= (index_cnt_r == INDEX_PERIOD - 1) ? 0 : index_cnt_r + 1;
            if (step_i && dir_i)
                pos_r[drive_sel_i] <= pos_r[drive_sel_i] + 8'h01;
            else if (step_i && pos_r[drive_sel_i] != 8'h00)
                pos_r[drive_sel_i] <= pos_r[drive_sel_i] - 8'h01;
        end
    end
    assign track_zero_o = (pos_r[drive_sel_i] == 8'h00);
    assign index_o = (index_cnt_r < 4);
endmodule // drive_model

/* sim/tb_top.sv */
`timescale 1ns/100ps
`include "seek_params.svh"
module tb_top;
    import seek_pkg::*;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic cmd_valid = 1'b0;
    cmd_t cmd = '0;
    logic sense = 1'b0;
    logic low_power = 1'b0;
    logic id_valid = 1'b0;
    id_field_t id = '0;
    logic track_zero, index, step, dir, busy, irq, ma;
    logic [1:0] drive_sel;
    status_zero_t st0;
    id_field_t id_seen;
    logic [7:0] present_cylinder;
    fmt_layout_t fmt;
    int fail_count = 0;
    int num_checks = 0;
    int step_cnt = 0;
    int busy_cnt = 0;
    logic last_dir = 1'b0;
    int gap_cnt = 0;
    logic [3:0] step_rate_time = 4'hF;
    // Host gap choices for 512-byte double-density sectors; no port carries them.
    localparam logic [7:0] gap_rw_len = `GPL_RW_512_MFM;
    localparam logic [7:0] gap_fmt_len = `GPL_FMT_512_MFM;

    always #5 clock_i = ~clock_i;

    seek_recal_ctrl dut (.clock_i(clock_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid),
        .cmd_i(cmd), .sense_i(sense), .step_rate_time_i(step_rate_time), .low_power_cmd_i(low_power),
        .id_valid_i(id_valid), .id_i(id), .track_zero_in_i(track_zero), .index_i(index),
        .step_o(step), .dir_o(dir), .drive_sel_o(drive_sel), .busy_o(busy), .irq_o(irq),
        .status_reg_zero_o(st0), .missing_address_mark_flag_o(ma), .id_o(id_seen),
        .present_cylinder_o(present_cylinder), .fmt_layout_o(fmt));

    drive_model drive (.clock_i(clock_i), .reset_i(reset_i), .step_i(step), .dir_i(dir),
        .drive_sel_i(drive_sel), .track_zero_o(track_zero), .index_o(index));

    always @(posedge clock_i)
    begin
        if (step === 1'b1)
        begin
            step_cnt++;
            last_dir = dir;
            gap_cnt = 0;
        end
        else if (irq !== 1'b1)
            gap_cnt++;
        if (busy === 1'b1)
            busy_cnt++;
    end

    task automatic conclude();
        if (fail_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic issue(input cmd_op_t op, input logic [1:0] drv, input logic [7:0] tgt);
        @(posedge clock_i);
        step_cnt = 0;
        busy_cnt = 0;
        cmd_valid <= 1'b1;
        cmd <= '{op: op, drive: drv, target_cylinder: tgt};
        @(posedge clock_i);
        cmd_valid <= 1'b0;
    endtask

    // Waits for the completion interrupt, then lets the late cylinder output settle.
    task automatic wait_irq(input int limit);
        int n;
        for (n = 0; n < limit && irq !== 1'b1; n++)
            @(posedge clock_i);
        if (irq !== 1'b1)
        begin
            fail_count++;
            conclude();
        end
        repeat (2) @(posedge clock_i);
    endtask

    task automatic sense_irq();
        sense <= 1'b1;
        @(posedge clock_i);
        sense <= 1'b0;
        repeat (2) @(posedge clock_i);
        check("irq", 32'h0, 32'(irq));
    endtask

    initial
    begin
        repeat (6) @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);
        check("fmt", 32'h0C32164E, 32'(fmt[31:0]));
        check("gap4a", 32'h50, 32'(fmt.gap4a_len));
        check("status", 32'h0, 32'(st0));
        // Recalibrate every drive after power-up; all heads already rest on track zero.
        for (int d = 0; d < 4; d++)
        begin
            issue(CMD_RECAL, 2'(d), 8'h00);
            wait_irq(100);
            check("status", 32'h10 + 32'(d), 32'(st0));
            check("steps", 32'h0, 32'(step_cnt));
            sense_irq();
        end
        // Seek one track inward on drive 1.
        issue(CMD_SEEK, 2'h1, 8'h01);
        wait_irq(80000);
        check("steps", 32'h1, 32'(step_cnt));
        check("dir", 32'h1, 32'(last_dir));
        check("status", 32'h11, 32'(st0));
        check("gap", 32'(`SRT_UNIT_CYC / `FIRST_GAP_DIV + 1), 32'(gap_cnt));
        check("drive_sel", 32'h1, 32'(drive_sel));
        check("pcn", 32'h1, 32'(present_cylinder));
        check("busy", 32'h1, 32'(busy_cnt));
        sense_irq();
        // Seek to the cylinder already held: no step at all.
        issue(CMD_SEEK, 2'h2, 8'h00);
        wait_irq(80000);
        check("steps", 32'h0, 32'(step_cnt));
        check("status", 32'h12, 32'(st0));
        sense_irq();
        // Recalibrate drive 1 back to track zero at a slower step rate.
        step_rate_time <= 4'hE;
        issue(CMD_RECAL, 2'h1, 8'h00);
        wait_irq(80000);
        check("steps", 32'h1, 32'(step_cnt));
        check("dir", 32'h0, 32'(last_dir));
        check("status", 32'h11, 32'(st0));
        check("gap", 32'(`SRT_UNIT_CYC * 2 / `FIRST_GAP_DIV + 1), 32'(gap_cnt));
        check("pcn", 32'h0, 32'(present_cylinder));
        check("busy", 32'h1, 32'(busy_cnt));
        sense_irq();
        // Read ID with a good field from the read channel.
        issue(CMD_READ_ID, 2'h0, 8'h00);
        repeat (10) @(posedge clock_i);
        id_valid <= 1'b1;
        id <= '{cyl: 8'h05, head: 8'h01, sector: 8'h03, size: 8'h02};
        @(posedge clock_i);
        id_valid <= 1'b0;
        wait_irq(10000);
        check("id", 32'h05010302, 32'(id_seen));
        check("ma", 32'h0, 32'(ma));
        check("ic", 32'h0, 32'(st0.interrupt_code_field));
        sense_irq();
        // Read ID with no mark before the second index pulse.
        issue(CMD_READ_ID, 2'h0, 8'h00);
        wait_irq(10000);
        check("ic", 32'h1, 32'(st0.interrupt_code_field));
        check("ma", 32'h1, 32'(ma));
        sense_irq();
        // Leave low power in the middle of a seek.
        issue(CMD_SEEK, 2'h3, 8'h05);
        repeat (20) @(posedge clock_i);
        low_power <= 1'b1;
        @(posedge clock_i);
        low_power <= 1'b0;
        repeat (3) @(posedge clock_i);
        check("pcn", 32'h0, 32'(present_cylinder));
        check("status", 32'h0, 32'(st0));
        check("irq", 32'h0, 32'(irq));
        conclude();
    end
endmodule // tb_top
